// *** giq_top.v ***
// Input qualifier for sixteen pins, APB register block and idle wake timing.
// Assumes an APB master on pclk; pins and the reset pin are asynchronous.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "giq_defines.vh"

module giq_top
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Pins
	input wire [`GIQ_NPINS-1:0] gpio_pin_in,
	output reg [`GIQ_NPINS-1:0] qualified_in,
	output reg [`GIQ_NPINS-1:0] pin_function_select,
	// Core and wake logic
	input wire idle_enter,
	input wire irq_pending,
	input wire watchdog_interrupt,
	input wire external_reset_pin_n,
	input wire flash_asleep,
	output reg cpu_idle,
	output reg cpu_resume
);

	localparam ST_RUN = 2'h0;
	localparam ST_SLEEP = 2'h1;
	localparam ST_WAKE = 2'h2;
	// Countdown loads; only the low counter bits are kept, and both values fit.
	localparam [31:0] CNT_ACTIVE_LAST = `GIQ_RESUME_ACTIVE_CYC - 1;
	localparam [31:0] CNT_SLEEP_LAST = `GIQ_RESUME_SLEEP_CYC - 1;

	reg [2*`GIQ_PERIOD_W-1:0] period_ff;
	reg [2*`GIQ_NPINS-1:0] qsel_ff;
	reg [2*`GIQ_NPINS-1:0] qsel_pipe_ff;
	reg [2*`GIQ_NPINS-1:0] qsel_eff_ff;
	reg [`GIQ_NPINS-1:0] func_ff;
	reg [`GIQ_NPINS-1:0] func_pipe_ff;
	reg [`GIQ_NPINS-1:0] wake_mask_ff;
	reg rst_sync1_ff;
	reg rst_sync2_ff;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`GIQ_RESUME_W-1:0] cnt_ff;
	reg [`GIQ_RESUME_W-1:0] nxt_cnt;
	reg nxt_resume;
	reg [31:0] nxt_rdata;
	reg nxt_err;
	wire [`GIQ_NPINS-1:0] qual_w;
	wire [`GIQ_NGROUPS-1:0] sample_en;
	wire setup;
	wire wr_access;
	wire wake;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Read data and error are prepared in the setup cycle so that the access
	// phase completes with no wait state and every output stays a flop.
	assign setup = psel & ~penable;
	assign wr_access = psel & penable & pwrite & pready;

	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_err = 1'b0;
		case (paddr)
			`GIQ_ADDR_PERIOD: nxt_rdata = {16'h0000, period_ff};
			`GIQ_ADDR_QSEL: nxt_rdata = qsel_ff;
			`GIQ_ADDR_FUNC: nxt_rdata = {16'h0000, func_ff};
			`GIQ_ADDR_DATA: nxt_rdata = {16'h0000, qualified_in};
			`GIQ_ADDR_WAKE: nxt_rdata = {16'h0000, wake_mask_ff};
			`GIQ_ADDR_STAT: nxt_rdata = {30'h0000_0000, (state_ff == ST_WAKE), cpu_idle};
			default: nxt_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & nxt_err;
			if (setup && !pwrite)
				prdata <= nxt_rdata;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_ff <= 16'h0000;
			qsel_ff <= 32'h0000_0000;
			func_ff <= 16'h0000;
			wake_mask_ff <= 16'h0000;
		end
		else if (wr_access)
		begin
			case (paddr)
				`GIQ_ADDR_PERIOD: period_ff <= pwdata[15:0];
				`GIQ_ADDR_QSEL: qsel_ff <= pwdata;
				`GIQ_ADDR_FUNC: func_ff <= pwdata[15:0];
				`GIQ_ADDR_WAKE: wake_mask_ff <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Select settings delay
	// ----------------------------------------
	// Two flop stages after the stored copy, so a write acts two clocks later.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			qsel_pipe_ff <= 32'h0000_0000;
			qsel_eff_ff <= 32'h0000_0000;
			func_pipe_ff <= 16'h0000;
			pin_function_select <= 16'h0000;
		end
		else
		begin
			qsel_pipe_ff <= qsel_ff;
			qsel_eff_ff <= qsel_pipe_ff;
			func_pipe_ff <= func_ff;
			pin_function_select <= func_pipe_ff;
		end
	end

	// ----------------------------------------
	// Sampling period dividers and pin qualifiers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `GIQ_NGROUPS; g = g + 1)
		begin : grp
			reg [`GIQ_PERIOD_W:0] div_ff;
			wire [`GIQ_PERIOD_W-1:0] n;
			wire [`GIQ_PERIOD_W:0] lim;
			assign n = period_ff[g*`GIQ_PERIOD_W +: `GIQ_PERIOD_W];
			assign lim = {n, 1'b0} - 9'h001;
			// A zero field makes the limit irrelevant: the pulse is every cycle.
			// The compare is not an equality, so a count left above a newly shortened
			// period restarts at once instead of running round all nine bits first.
			assign sample_en[g] = (n == 8'h00) | (div_ff >= lim);
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					div_ff <= 9'h000;
				else if (sample_en[g])
					div_ff <= 9'h000;
				else
					div_ff <= div_ff + 9'h001;
			end
		end
	endgenerate

	genvar p;
	generate
		for (p = 0; p < `GIQ_NPINS; p = p + 1)
		begin : pin
			giq_qual u_qual
			(
				.pclk(pclk),
				.presetn(presetn),
				.pin_in(gpio_pin_in[p]),
				.sample_en(sample_en[p / `GIQ_GROUP_SIZE]),
				.mode(qsel_eff_ff[2*p +: 2]),
				.qual_out(qual_w[p])
			);
		end
	endgenerate

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			qualified_in <= 16'h0000;
		else
			qualified_in <= qual_w;
	end

	// ----------------------------------------
	// Idle wake sequencer
	// ----------------------------------------
	// The reset pin is asynchronous and is synchronised before it can wake.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= 1'b1;
		end
		else
		begin
			rst_sync1_ff <= external_reset_pin_n;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end

	// A wake through a pin arrives already qualified, so the window adds to
	// the resume delay by itself.
	assign wake = irq_pending | watchdog_interrupt | ~rst_sync2_ff | (|(qualified_in & wake_mask_ff));

	always @*
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_resume = 1'b0;
		case (state_ff)
			ST_RUN:
			begin
				if (idle_enter)
					nxt_state = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				// Only a sleeping core listens to wake; run and countdown ignore it.
				if (wake)
				begin
					nxt_state = ST_WAKE;
					if (flash_asleep)
						nxt_cnt = CNT_SLEEP_LAST[`GIQ_RESUME_W-1:0];
					else
						nxt_cnt = CNT_ACTIVE_LAST[`GIQ_RESUME_W-1:0];
				end
			end
			ST_WAKE:
			begin
				if (cnt_ff == 11'h000)
				begin
					// Resume marks the instruction after idle; handler entry is later.
					nxt_state = ST_RUN;
					nxt_resume = 1'b1;
				end
				else
					nxt_cnt = cnt_ff - 11'h001;
			end
			default:
				nxt_state = ST_RUN;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_RUN;
			cnt_ff <= 11'h000;
			cpu_idle <= 1'b0;
			cpu_resume <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cpu_idle <= (nxt_state != ST_RUN);
			cpu_resume <= nxt_resume;
		end
	end

endmodule
`default_nettype wire

// *** giq_defines.vh ***
// Constants shared by the input qualifier and its register block.
// Assumes inclusion by bare name from files that need the offsets and codes.
`ifndef GIQ_DEFINES_VH
`define GIQ_DEFINES_VH

// ----------------------------------------
// Structure
// ----------------------------------------
`define GIQ_NPINS 16
`define GIQ_GROUP_SIZE 8
`define GIQ_NGROUPS 2
`define GIQ_PERIOD_W 8
`define GIQ_HIST_W 6

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define GIQ_ADDR_PERIOD 8'h00
`define GIQ_ADDR_QSEL 8'h04
`define GIQ_ADDR_FUNC 8'h08
`define GIQ_ADDR_DATA 8'h0C
`define GIQ_ADDR_WAKE 8'h10
`define GIQ_ADDR_STAT 8'h14

// ----------------------------------------
// Qualifier select codes
// ----------------------------------------
`define GIQ_QSEL_SYNC 2'h0
`define GIQ_QSEL_3S 2'h1
`define GIQ_QSEL_6S 2'h2
`define GIQ_QSEL_ASYNC 2'h3

// ----------------------------------------
// Timing in system clock cycles, and the resume counter width
// ----------------------------------------
`define GIQ_RESUME_ACTIVE_CYC 20
`define GIQ_RESUME_SLEEP_CYC 1050
`define GIQ_RESUME_W 11
`define GIQ_CFG_DELAY 2

`endif

// *** giq_qual.v ***
// One pin of the input qualifier: synchroniser, sample history and output.
// Assumes sample_en is a one-cycle pulse on pclk from the group's period divider.
`timescale 1ns/1ps
`default_nettype none
`include "giq_defines.vh"

module giq_qual
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Pin and control
	input wire pin_in,
	input wire sample_en,
	input wire [1:0] mode,
	// Qualified level
	output wire qual_out
);

	reg sync1_ff;
	reg sync2_ff;
	reg [`GIQ_HIST_W-1:0] hist_ff;
	reg out_ff;
	wire all3_hi;
	wire all3_lo;
	wire all6_hi;
	wire all6_lo;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end

	// ----------------------------------------
	// Sample history and qualified output
	// ----------------------------------------
	assign all3_hi = &hist_ff[2:0];
	assign all3_lo = ~|hist_ff[2:0];
	assign all6_hi = &hist_ff;
	assign all6_lo = ~|hist_ff;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hist_ff <= {`GIQ_HIST_W{1'b0}};
		else if (sample_en)
			hist_ff <= {hist_ff[`GIQ_HIST_W-2:0], sync2_ff};
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_ff <= 1'b0;
		else
		begin
			case (mode)
				`GIQ_QSEL_3S:
				begin
					// Three samples span two periods.
					if (all3_hi)
						out_ff <= 1'b1;
					else if (all3_lo)
						out_ff <= 1'b0;
				end
				`GIQ_QSEL_6S:
				begin
					// Six samples span five periods.
					if (all6_hi)
						out_ff <= 1'b1;
					else if (all6_lo)
						out_ff <= 1'b0;
				end
				default:
					out_ff <= sync2_ff;
			endcase
		end
	end

	assign qual_out = out_ff;

endmodule
`default_nettype wire

// *** giq_top_sva.sv ***
// Port-level assertions for giq_top, bound below the checker module.
// Assumes one domain: pclk with presetn as its reset.
`timescale 1ns/1ps
`default_nettype none
`include "giq_defines.vh"
module giq_top_sva
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic [`GIQ_NPINS-1:0] gpio_pin_in,
	input wire logic [`GIQ_NPINS-1:0] qualified_in,
	input wire logic [`GIQ_NPINS-1:0] pin_function_select,
	// Wake
	input wire logic idle_enter,
	input wire logic irq_pending,
	input wire logic flash_asleep,
	input wire logic cpu_idle,
	input wire logic cpu_resume
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_setup;
	psel && !penable;
endsequence
sequence s_func_wr;
	psel && penable && pready && pwrite && paddr == `GIQ_ADDR_FUNC;
endsequence
a_ready_after_setup: assert property (s_setup |=> pready) else $error("no pready");
a_ready_one_cycle: assert property (pready |-> ($past(psel) && !$past(penable)) ##1 !pready)
	else $error("pready shape");
a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
a_func_delay: assert property (s_func_wr |-> ##2 $stable(pin_function_select)
	##1 pin_function_select == $past(pwdata[15:0], 3)) else $error("func delay");
a_idle_entry: assert property (idle_enter && !cpu_idle && !cpu_resume |=> cpu_idle)
	else $error("idle not entered");
a_resume_irq: assert property ($rose(irq_pending) && cpu_idle && !flash_asleep |-> ##21 cpu_resume)
	else $error("resume late");
a_resume_pulse: assert property (cpu_resume |-> !cpu_idle && $past(cpu_idle) ##1 !cpu_resume)
	else $error("resume pulse");
a_sync_follow: assert property ($changed(qualified_in[0]) |-> qualified_in[0] == $past(gpio_pin_in[0], 4))
	else $error("sync latency");
endmodule
bind giq_top giq_top_sva u_sva
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .gpio_pin_in,
	.qualified_in, .pin_function_select, .idle_enter, .irq_pending, .flash_asleep, .cpu_idle, .cpu_resume
);
`default_nettype wire

// *** giq_pin_drv.sv ***
// Behavioural driver of the sixteen pin inputs.
// Assumes it is the only driver of the pins and is called right after an edge.
`timescale 1ns/1ps
`default_nettype none
module giq_pin_drv
(
	// Clock
	input wire logic pclk,
	// Pin levels
	output var logic [15:0] pins
);
initial pins = 16'h0000;
// Widths under two clocks are only asked for as glitches in windowed modes.
task pulse(input int p, input int w);
	@(posedge pclk);
	pins[p] <= 1'b1;
	repeat (w) @(posedge pclk);
	pins[p] <= 1'b0;
endtask
endmodule
`default_nettype wire

// *** giq_top_test.sv ***
// Self-checking bench for giq_top: APB master, pin driver and wake stimulus.
// Assumes the checker binds itself to giq_top.
`timescale 1ns/1ps
`default_nettype none
`include "giq_defines.vh"
module giq_top_test;
logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic pready, pslverr, err, cpu_idle, cpu_resume;
logic [15:0] gpio_pin_in, qualified_in, pin_function_select;
logic idle_enter = 1'b0, irq_pending = 1'b0, watchdog_interrupt = 1'b0;
logic external_reset_pin_n = 1'b1, flash_asleep = 1'b0;
int num_errors = 0;
int tests_run = 0;
always #20 pclk = ~pclk;
giq_top dut
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.gpio_pin_in, .qualified_in, .pin_function_select, .idle_enter, .irq_pending,
	.watchdog_interrupt, .external_reset_pin_n, .flash_asleep, .cpu_idle, .cpu_resume
);
giq_pin_drv drv (.pclk(pclk), .pins(gpio_pin_in));
task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
	tests_run++;
	if (got !== exp)
	begin
		num_errors++;
		$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
	end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge pclk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	do @(posedge pclk); while (pready !== 1'b1);
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
task automatic t_regs;
	for (int a = 0; a < 24; a += 4)
	begin
		apb(1'b0, a[7:0], 32'h0);
		chk({err, rd}, 33'h0, "reset value");
	end
	apb(1'b0, 8'h18, 32'h0);
	chk({err, rd}, {1'b1, 32'h0}, "unmapped");
	apb(1'b1, `GIQ_ADDR_PERIOD, 32'hFFFFFFFF);
	apb(1'b0, `GIQ_ADDR_PERIOD, 32'h0);
	chk({err, rd}, 33'h0FFFF, "period max");
	apb(1'b1, `GIQ_ADDR_FUNC, 32'h0000A5C3);
	@(posedge pclk);
	#1 chk({17'h0, pin_function_select}, 33'h0, "func early");
	@(posedge pclk);
	#1 chk({17'h0, pin_function_select}, 33'h0A5C3, "func late");
	$display("regs done");
endtask
// Each row is a pin and a pulse width; expv bit i says whether row i passes.
task automatic t_qual;
	int pin[9] = '{3, 0, 1, 1, 2, 2, 7, 8, 8};
	int wid[9] = '{2, 2, 2, 3, 5, 6, 3, 7, 12};
	logic [8:0] expv = 9'h16B;
	logic seen;
	apb(1'b1, `GIQ_ADDR_PERIOD, 32'h00000200);
	apb(1'b1, `GIQ_ADDR_QSEL, 32'h00014027);
	apb(1'b0, `GIQ_ADDR_QSEL, 32'h0);
	chk({err, rd}, 33'h14027, "qsel");
	for (int i = 0; i < 9; i++)
	begin
		seen = 1'b0;
		fork
			drv.pulse(pin[i], wid[i]);
			repeat (wid[i] + 40) @(posedge pclk) seen |= qualified_in[pin[i]];
		join
		chk({32'h0, seen}, {32'h0, expv[i]}, "pulse");
	end
	$display("qual done");
endtask
task automatic t_wake(input int src, input logic slow, input int exp);
	int n = 0;
	@(posedge pclk);
	idle_enter <= 1'b1;
	flash_asleep <= slow;
	@(posedge pclk);
	idle_enter <= 1'b0;
	repeat (5) @(posedge pclk);
	chk({32'h0, cpu_idle}, 33'h1, "idle");
	case (src)
		0: irq_pending <= 1'b1;
		1: watchdog_interrupt <= 1'b1;
		2: external_reset_pin_n <= 1'b0;
		default:
			fork
				drv.pulse(3, 2);
			join_none
	endcase
	while (cpu_resume !== 1'b1 && n < 1200)
	begin
		@(posedge pclk);
		if (n == 1)
			{irq_pending, watchdog_interrupt, external_reset_pin_n} <= 3'b001;
		#1;
		n++;
	end
	chk(33'(n), 33'(exp), "resume delay");
	chk({32'h0, cpu_idle}, 33'h0, "awake");
	$display("wake done");
endtask
task automatic summarize;
	$display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
	if (num_errors == 0 && tests_run > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
initial
begin
	repeat (20) @(posedge pclk);
	presetn <= 1'b1;
	t_regs();
	t_qual();
	t_wake(0, 1'b0, 21);
	t_wake(1, 1'b0, 21);
	t_wake(2, 1'b0, 23);
	apb(1'b1, `GIQ_ADDR_WAKE, 32'h00000008);
	t_wake(3, 1'b0, 26);
	t_wake(0, 1'b1, 1051);
	summarize();
end
initial
begin
	repeat (8000) @(posedge pclk);
	num_errors++;
	summarize();
end
endmodule
`default_nettype wire
